// >>> hdl/dsacr_config_regs.sv
// Serial-port config bank: sync, latency, alarms, scale, temperature
`timescale 1ns/1ps
`include "dsacr_cfg.svh"
module dsacr_config_regs
  import dsacr_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Serial control interface pins
  input wire logic sif_clk_i,
  input wire logic sif_enable_n_i,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe_n_o,
  // External frame strobe pin
  input wire logic frame_sync_i,
  // Multi-device sync enable from the main control register
  input wire logic multi_sync_en_i,
  // Raw temperature sensor code, asynchronous
  input wire logic [7:0] temp_sensor_i,
  // Sample path
  input wire dsacr_sample_t sample_i,
  output dsacr_sample_t sample_o,
  // Alarm path, same clock domain
  input wire logic [6:0] alarm_event_i,
  input wire logic [6:0] alarm_sw_clear_i,
  input wire logic good_sample_i,
  output logic [6:0] alarm_latched_o,
  output logic alarm_output_pin_o,
  // Towards FIFO and analog core
  output dsacr_sync_t fifo_sync_o,
  output dsacr_scale_t current_scale_o
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************

  // Bit layout of the synchronised pin vector
  localparam int P_SCLK = 11;
  localparam int P_EN_N = 10;
  localparam int P_SDIO = 9;
  localparam int P_FRAME = 8;
  // Enable idles high, so it resets high to look like no frame
  localparam logic [11:0] PIN_RST = 12'h400;

  wire [11:0] pin_raw = {sif_clk_i, sif_enable_n_i, sdio_i,
                         frame_sync_i, temp_sensor_i};
  logic [11:0] pin_sync;

  genvar gp;
  generate
    for (gp = 0; gp < 12; gp = gp + 1) begin : g_sync
      logic meta_reg;
      logic sync_reg;
      // Two flops per pin; only the second is read
      always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          meta_reg <= PIN_RST[gp];
          sync_reg <= PIN_RST[gp];
        end else begin
          meta_reg <= pin_raw[gp];
          sync_reg <= meta_reg;
        end
      end
      assign pin_sync[gp] = sync_reg;
    end
  endgenerate

  wire sclk_s = pin_sync[P_SCLK];
  wire en_n_s = pin_sync[P_EN_N];
  wire sdio_s = pin_sync[P_SDIO];
  wire frame_s = pin_sync[P_FRAME];
  wire [7:0] temp_s = pin_sync[7:0];

  // ************************************************************
  // Configuration registers
  // ************************************************************

  logic [7:0] sync_lat_reg;   // Sync request, sync select, latency
  logic [7:0] fifo_alm_reg;   // Autoclear, offset, distance alarms
  logic [7:0] scale_reg;      // Current steps for A and B
  logic [7:0] mask_reg;       // Pin mask for the seven alarms
  logic [7:0] temp_hold_reg;  // Settled temperature code
  logic [7:0] temp_prev_reg;  // Last synchronised temperature code

  // ************************************************************
  // Serial port state
  // ************************************************************

  dsacr_sif_state_t state_reg;
  dsacr_sif_state_t state_next;
  logic [2:0] bit_cnt_reg;    // Bits taken in the current byte
  logic [2:0] bit_cnt_next;
  logic [7:0] shift_in_reg;   // Incoming bits, MSB first
  logic [7:0] shift_in_next;
  logic rw_reg;               // High for a read transfer
  logic rw_next;
  logic [4:0] addr_reg;       // Current register address
  logic [4:0] addr_next;
  logic [7:0] rd_shift_reg;   // Outgoing bits, MSB first
  logic [7:0] rd_shift_next;
  logic drive_reg;            // Device owns the data pin
  logic drive_next;
  logic sclk_prev_reg;        // Serial clock one cycle ago

  // Edges of the synchronised serial clock
  wire sclk_rise = sclk_s & ~sclk_prev_reg;
  wire sclk_fall = ~sclk_s & sclk_prev_reg;
  // Byte with the new bit appended
  wire [7:0] shift_word = {shift_in_reg[6:0], sdio_s};
  // Eighth rising edge closes a byte
  wire byte_done = sclk_rise & (bit_cnt_reg == 3'h7);
  wire in_data = (state_reg == DSACR_ST_DATA);
  wire [4:0] addr_inc = addr_reg + 5'h01;

  // Read view of one address; unmapped addresses read as zero
  function automatic logic [7:0] reg_read(input logic [4:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `DSACR_ADDR_SYNC_LAT: v = sync_lat_reg;
      `DSACR_ADDR_FIFO_ALM: v = fifo_alm_reg;
      `DSACR_ADDR_SCALE: v = scale_reg;
      `DSACR_ADDR_TEMP: v = temp_hold_reg; // see [R10]
      `DSACR_ADDR_MASK: v = mask_reg;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // First read byte comes from the address in the instruction,
  // later ones from the next address up
  wire [7:0] rd_first = reg_read(shift_word[4:0]);
  wire [7:0] rd_follow = reg_read(addr_inc);

  // ************************************************************
  // Serial port next-state logic
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_in_next = shift_in_reg;
    rw_next = rw_reg;
    addr_next = addr_reg;
    rd_shift_next = rd_shift_reg;
    drive_next = drive_reg;
    if (en_n_s) begin
      // Frame ended: back to idle, clear the bit count and release the pin
      state_next = DSACR_ST_IDLE;
      bit_cnt_next = 3'h0;
      drive_next = 1'b0;
    end else begin
      case (state_reg)
        DSACR_ST_IDLE: begin
          // Enable must lead the first clock by one system cycle
          state_next = DSACR_ST_INSTR;
          bit_cnt_next = 3'h0;
        end
        DSACR_ST_INSTR: begin
          if (sclk_rise) begin
            shift_in_next = shift_word;
            bit_cnt_next = bit_cnt_reg + 3'h1;
          end
          if (byte_done) begin
            // Instruction complete: direction and address known
            rw_next = shift_word[`DSACR_INSTR_RW_BIT];
            addr_next = shift_word[4:0];
            rd_shift_next = rd_first;
            drive_next = shift_word[`DSACR_INSTR_RW_BIT];
            state_next = DSACR_ST_DATA;
          end
        end
        DSACR_ST_DATA: begin
          if (sclk_rise) begin
            shift_in_next = shift_word;
            bit_cnt_next = bit_cnt_reg + 3'h1;
          end
          if (byte_done) begin
            // Stream on to the next address
            addr_next = addr_inc;
            rd_shift_next = rd_follow;
          end else if (sclk_fall && rw_reg && bit_cnt_reg != 3'h0) begin
            // Host took a bit on the rising edge, show the next one
            rd_shift_next = {rd_shift_reg[6:0], 1'b0};
          end
        end
        default: begin
          state_next = DSACR_ST_IDLE;
          bit_cnt_next = 3'h0;
          drive_next = 1'b0;
        end
      endcase
    end
  end

  // Serial port flops
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= DSACR_ST_IDLE;
      bit_cnt_reg <= 3'h0;
      shift_in_reg <= 8'h00;
      rw_reg <= 1'b0;
      addr_reg <= 5'h00;
      rd_shift_reg <= 8'h00;
      drive_reg <= 1'b0;
      sclk_prev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_in_reg <= shift_in_next;
      rw_reg <= rw_next;
      addr_reg <= addr_next;
      rd_shift_reg <= rd_shift_next;
      drive_reg <= drive_next;
      sclk_prev_reg <= sclk_s;
    end
  end

  assign sdio_o = rd_shift_reg[7];
  // Enable is active low while the device drives the pin
  assign sdio_oe_n_o = ~drive_reg;

  // ************************************************************
  // Register write decode
  // ************************************************************

  // A write lands when the last bit of a data byte arrives
  wire wr_strobe = in_data & byte_done & ~rw_reg;
  wire wr_sync_lat = wr_strobe & (addr_reg == `DSACR_ADDR_SYNC_LAT);
  wire wr_fifo_alm = wr_strobe & (addr_reg == `DSACR_ADDR_FIFO_ALM);
  wire wr_scale = wr_strobe & (addr_reg == `DSACR_ADDR_SCALE);
  wire wr_mask = wr_strobe & (addr_reg == `DSACR_ADDR_MASK);
  // Writes to the temperature address fall through and are lost

  // Writable registers keep all eight bits, unused ones included
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync_lat_reg <= `DSACR_RST_SYNC_LAT; // see [R13]
      fifo_alm_reg <= `DSACR_RST_FIFO_ALM; // see [R5]
      scale_reg <= `DSACR_RST_SCALE; // see [R8]
      mask_reg <= `DSACR_RST_MASK; // see [R15]
    end else begin
      if (wr_sync_lat) begin
        sync_lat_reg <= shift_word; // see [R14]
      end
      if (wr_fifo_alm) begin
        fifo_alm_reg <= shift_word;
      end
      if (wr_scale) begin
        scale_reg <= shift_word; // see [R9]
      end
      if (wr_mask) begin
        mask_reg <= shift_word;
      end
    end
  end

  // ************************************************************
  // Temperature capture
  // ************************************************************

  // Sensor bits are synchronised one by one and may tear while the
  // code moves; only a code seen twice in a row is taken. A slow
  // host clock gives the value time to settle before it is read.
  wire temp_stable = (temp_s == temp_prev_reg);

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      temp_prev_reg <= 8'h00;
      temp_hold_reg <= 8'h00;
    end else begin
      temp_prev_reg <= temp_s;
      if (temp_stable) begin
        temp_hold_reg <= temp_s; // see [R12]
      end
    end
  end

  // ************************************************************
  // Sync source selection and read-pointer load
  // ************************************************************

  // Fields of the sync and latency register
  wire sif_sync = sync_lat_reg[`DSACR_SIF_SYNC_BIT];
  wire sif_sync_sel = sync_lat_reg[`DSACR_SIF_SYNC_EN_BIT];
  wire [1:0] out_delay =
    sync_lat_reg[`DSACR_OUT_DLY_MSB:`DSACR_OUT_DLY_LSB];

  // Software sync replaces the frame strobe entirely when selected
  wire sync_sel = sif_sync_sel ? sif_sync : frame_s; // see [R1] [R2]
  logic sync_prev_reg;
  logic [4:0] fifo_sync_reg;

  // Only a rising level loads, so a held request gives one load
  wire sync_rise = sync_sel & ~sync_prev_reg; // see [R18]
  wire load_now = multi_sync_en_i & sync_rise; // see [R17]
  wire [2:0] fifo_offset =
    fifo_alm_reg[`DSACR_OFFSET_MSB:`DSACR_OFFSET_LSB];

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync_prev_reg <= 1'b0;
      fifo_sync_reg <= 5'h00;
    end else begin
      sync_prev_reg <= sync_sel;
      fifo_sync_reg <= {sync_sel, load_now, fifo_offset}; // see [R5]
    end
  end

  assign fifo_sync_o = dsacr_sync_t'(fifo_sync_reg);

  // ************************************************************
  // Current scale outputs
  // ************************************************************

  // Step n gives n+1 sixteenths of full scale in the analog core
  assign current_scale_o.scale_a =
    scale_reg[`DSACR_SCALE_A_MSB:`DSACR_SCALE_A_LSB]; // see [R8]
  assign current_scale_o.scale_b =
    scale_reg[`DSACR_SCALE_B_MSB:`DSACR_SCALE_B_LSB]; // see [R9]

  // ************************************************************
  // Output latency
  // ************************************************************

  // Latency is applied to both channels together
  dsacr_out_delay u_out_delay (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .delay_sel_i(out_delay), // see [R3]
    .sample_i(sample_i),
    .sample_o(sample_o)
  );

  // ************************************************************
  // Alarm handling
  // ************************************************************

  dsacr_alarm_ac u_alarm (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .alarm_event_i(alarm_event_i),
    .alarm_sw_clear_i(alarm_sw_clear_i),
    .good_sample_i(good_sample_i),
    .near_collision_one_alarm_en_i(fifo_alm_reg[`DSACR_ALM_ONE_BIT]),
    .near_collision_two_alarm_en_i(fifo_alm_reg[`DSACR_ALM_TWO_BIT]),
    .good_sample_autoclear_en_i(fifo_alm_reg[`DSACR_AUTOCLR_BIT]),
    .mask_i(mask_reg[`DSACR_MASK_MSB:0]), // see [R16]
    .alarm_latched_o(alarm_latched_o),
    .alarm_output_pin_o(alarm_output_pin_o)
  );

endmodule

// >>> hdl/dsacr_cfg.svh
// Offsets, field positions, reset values and counts of the config bank
//
// Summary of operation
// [R1] Sync request bit 5 asserts software sync
// [R2] Sync select bit 4 replaces frame strobe
// [R3] Latency field 1:0 delays samples 0-3
// [R4] Bit 7: clear alarms after 64 good
// [R5] Offset 4:2, reset 100, loads read pointer
// [R6] Bit 1 enables two-away pointer alarms
// [R7] Bit 0 enables one-away pointer alarms
// [R8] Channel A scale 7:4, reset 1111
// [R9] Channel B scale 3:0, reset 1111
// [R10] Temperature is eight-bit two's complement Celsius
// [R11] Host reads temperature with slow clock
// [R12] Temperature at 0x05 is read only
// [R13] Resets 0x00, 0x10, 0xFF, 0x00
// [R14] Unused bits are storage, reset zero
// [R15] Mask register: seven mask bits, reset zero
// [R16] Masked alarm kept off the pin
// [R17] Selected sync reloads read pointer offset
// [R18] Software sync is a level
// [R19] New alarm restarts good-sample count
`ifndef DSACR_CFG_SVH
`define DSACR_CFG_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define DSACR_ADDR_SYNC_LAT 5'h02
`define DSACR_ADDR_FIFO_ALM 5'h03
`define DSACR_ADDR_SCALE 5'h04
`define DSACR_ADDR_TEMP 5'h05
`define DSACR_ADDR_MASK 5'h06

// ************************************************************
// Field positions
// ************************************************************
`define DSACR_SIF_SYNC_BIT 5
`define DSACR_SIF_SYNC_EN_BIT 4
`define DSACR_OUT_DLY_MSB 1
`define DSACR_OUT_DLY_LSB 0
`define DSACR_AUTOCLR_BIT 7
`define DSACR_OFFSET_MSB 4
`define DSACR_OFFSET_LSB 2
`define DSACR_ALM_TWO_BIT 1
`define DSACR_ALM_ONE_BIT 0
`define DSACR_SCALE_A_MSB 7
`define DSACR_SCALE_A_LSB 4
`define DSACR_SCALE_B_MSB 3
`define DSACR_SCALE_B_LSB 0
`define DSACR_MASK_MSB 6
`define DSACR_INSTR_RW_BIT 7

// ************************************************************
// Reset values and counts
// ************************************************************
`define DSACR_RST_SYNC_LAT 8'h00
`define DSACR_RST_FIFO_ALM 8'h10
`define DSACR_RST_SCALE 8'hFF
`define DSACR_RST_MASK 8'h00
`define DSACR_GOOD_RUN 7'h40
`define DSACR_TEMP_SCLK_MIN_NS 1000

`endif

// >>> hdl/dsacr_pkg.sv
// Types shared by the config bank and its helper modules
package dsacr_pkg;

  // Serial port states, Gray coded along idle, instruction, data
  typedef enum logic [1:0] {
    DSACR_ST_IDLE = 2'b00,
    DSACR_ST_INSTR = 2'b01,
    DSACR_ST_DATA = 2'b11
  } dsacr_sif_state_t;

  // One sample for each converter
  typedef struct packed {
    logic [15:0] chan_a;
    logic [15:0] chan_b;
  } dsacr_sample_t;

  // Output current steps for both converters
  typedef struct packed {
    logic [3:0] scale_a;
    logic [3:0] scale_b;
  } dsacr_scale_t;

  // Sync towards the FIFO read side
  typedef struct packed {
    logic level;
    logic load;
    logic [2:0] offset;
  } dsacr_sync_t;

endpackage

// >>> hdl/dsacr_out_delay.sv
// Selectable output latency line for the converter samples
`timescale 1ns/1ps
module dsacr_out_delay
  import dsacr_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [1:0] delay_sel_i,
  input wire dsacr_sample_t sample_i,
  output dsacr_sample_t sample_o
);

  // Stage 0 is the input itself, stages 1..3 are flops
  dsacr_sample_t stage [0:3];
  dsacr_sample_t out_reg;

  assign stage[0] = sample_i;

  // ************************************************************
  // Delay stages
  // ************************************************************
  genvar gi;
  generate
    for (gi = 1; gi < 4; gi = gi + 1) begin : g_stage
      dsacr_sample_t stage_reg;
      // Shift one stage per clock
      always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          stage_reg <= '0;
        end else begin
          stage_reg <= stage[gi-1];
        end
      end
      assign stage[gi] = stage_reg;
    end
  endgenerate

  // Output flop adds one fixed cycle on top of the chosen tap
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_reg <= '0;
    end else begin
      out_reg <= stage[delay_sel_i]; // see [R3]
    end
  end

  assign sample_o = out_reg;

endmodule

// >>> hdl/dsacr_alarm_ac.sv
// Alarm latch, pin masking and good-sample automatic clearing
`timescale 1ns/1ps
`include "dsacr_cfg.svh"
module dsacr_alarm_ac
  import dsacr_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [6:0] alarm_event_i,
  input wire logic [6:0] alarm_sw_clear_i,
  input wire logic good_sample_i,
  input wire logic near_collision_one_alarm_en_i,
  input wire logic near_collision_two_alarm_en_i,
  input wire logic good_sample_autoclear_en_i,
  input wire logic [6:0] mask_i,
  output logic [6:0] alarm_latched_o,
  output logic alarm_output_pin_o
);

  logic [6:0] latched_reg;
  logic [6:0] latched_next;
  logic [6:0] good_cnt_reg;
  logic [6:0] good_cnt_next;
  logic pin_reg;

  // Pointer-distance alarms only count when enabled
  wire [6:0] gate = {5'h1F, near_collision_two_alarm_en_i, // see [R6]
                     near_collision_one_alarm_en_i}; // see [R7]
  wire [6:0] event_g = alarm_event_i & gate;
  wire any_event = |event_g;
  // Run of good samples ends the latched alarms
  wire run_done = good_sample_autoclear_en_i & good_sample_i &
                  (good_cnt_reg == (`DSACR_GOOD_RUN - 7'h01)); // see [R4]
  wire [6:0] clr = alarm_sw_clear_i | {7{run_done}};

  // A new event wins over any clear in the same cycle
  assign latched_next = (latched_reg & ~clr) | event_g;

  // Counter restarts on every new alarm, so the run is unbroken
  assign good_cnt_next = (any_event | run_done |
                          !good_sample_autoclear_en_i) ? 7'h00 : // see [R19]
                         good_sample_i ? good_cnt_reg + 7'h01 :
                         good_cnt_reg;

  // ************************************************************
  // State
  // ************************************************************
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      latched_reg <= 7'h00;
      good_cnt_reg <= 7'h00;
      pin_reg <= 1'b0;
    end else begin
      latched_reg <= latched_next;
      good_cnt_reg <= good_cnt_next;
      pin_reg <= |(latched_next & ~mask_i); // see [R16]
    end
  end

  assign alarm_latched_o = latched_reg;
  assign alarm_output_pin_o = pin_reg;

endmodule

// >>> verification/dsacr_host_model.sv
// Serial control host model for the config bank
`timescale 1ns/1ps
module dsacr_host_model (
  input wire logic clk_sys_i,
  input wire logic sdio_wire_i,
  output logic sif_clk_o,
  output logic sif_enable_n_o,
  output logic sdio_host_o
);
  // ****
  // Frame engine
  // ****
  initial begin
    sif_clk_o = 1'b0; // Idles low
    sif_enable_n_o = 1'b1;
    sdio_host_o = 1'b0;
  end
  // Five clocks a phase: a 1 us period, fit for the temperature read
  task automatic xfer(input logic rd, input logic [4:0] a,
                      input logic [7:0] wd, output logic [7:0] rdat);
    logic [15:0] w;
    w = {rd, 2'b00, a, wd};
    @(posedge clk_sys_i);
    sif_enable_n_o <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    for (int i = 15; i >= 0; i--) begin
      // Toggled while released so no stale level survives
      sdio_host_o <= (rd && i < 8) ? ~sdio_host_o : w[i];
      repeat (5) @(posedge clk_sys_i);
      sif_clk_o <= 1'b1;
      if (i < 8) rdat[i] = sdio_wire_i;
      repeat (5) @(posedge clk_sys_i);
      sif_clk_o <= 1'b0;
    end
    repeat (5) @(posedge clk_sys_i);
    sif_enable_n_o <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
  endtask
endmodule

// >>> verification/dsacr_config_regs_sva.sv
// Port-level checker of the config bank
`timescale 1ns/1ps
module dsacr_config_regs_sva
  import dsacr_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic sif_enable_n_i,
  input wire logic multi_sync_en_i,
  input wire dsacr_sample_t sample_i,
  input wire dsacr_sample_t sample_o,
  input wire logic [6:0] alarm_event_i,
  input wire logic [6:0] alarm_sw_clear_i,
  input wire logic good_sample_i,
  input wire logic [6:0] alarm_latched_o,
  input wire logic alarm_output_pin_o,
  input wire dsacr_sync_t fifo_sync_o,
  input wire dsacr_scale_t current_scale_o
);
  // ****
  // Assertions
  // ****
  logic [2:0] up_reg; // Cycles since reset
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
    if (!reset_n_i) up_reg <= 3'h0;
    else if (up_reg != 3'h7) up_reg <= up_reg + 3'h1;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  a_load_level: assert property (
    fifo_sync_o.load |-> fifo_sync_o.level) else $error("load no level");
  a_load_enable: assert property (
    fifo_sync_o.load |-> $past(multi_sync_en_i)) else $error("load off");
  a_load_single: assert property (
    fifo_sync_o.load |=> !fifo_sync_o.load) else $error("load too long");
  a_latency_hold: assert property (
    (up_reg == 3'h7 && $stable(sample_i))[*5] |-> sample_o == sample_i)
    else $error("sample path stuck");
  a_pin_cause: assert property (
    alarm_output_pin_o |-> |alarm_latched_o) else $error("pin no alarm");
  a_set_cause: assert property (
    (alarm_latched_o & ~$past(alarm_latched_o) & ~$past(alarm_event_i))
    == 7'h00) else $error("alarm set without event");
  a_clear_cause: assert property (
    |($past(alarm_latched_o) & ~alarm_latched_o) |->
    $past(|alarm_sw_clear_i || good_sample_i)) else $error("bad clear");
  a_scale_write: assert property (
    $changed(current_scale_o) |-> !sif_enable_n_i)
    else $error("scale moved outside frame");
  a_scale_reset: assert property (
    $rose(reset_n_i) |-> current_scale_o == 8'hFF)
    else $error("scale reset value");
endmodule
bind dsacr_config_regs dsacr_config_regs_sva dsacr_config_regs_sva_inst (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
  .sif_enable_n_i(sif_enable_n_i), .multi_sync_en_i(multi_sync_en_i),
  .sample_i(sample_i), .sample_o(sample_o), .alarm_event_i(alarm_event_i),
  .alarm_sw_clear_i(alarm_sw_clear_i), .good_sample_i(good_sample_i),
  .alarm_latched_o(alarm_latched_o), .fifo_sync_o(fifo_sync_o),
  .alarm_output_pin_o(alarm_output_pin_o),
  .current_scale_o(current_scale_o));

// >>> verification/tb_top.sv
// Self-checking bench of the serial config bank
`timescale 1ns/1ps
module tb_top;
  import dsacr_pkg::*;
  // ****
  // Signals and instances
  // ****
  logic clk_sys_i, reset_n_i, sif_clk_i, sif_enable_n_i, sdio_i, sdio_o;
  logic sdio_oe_n_o, frame_sync_i, multi_sync_en_i, good_sample_i;
  logic alarm_output_pin_o, sdio_host;
  logic [7:0] temp_sensor_i, rd, v, t;
  logic [6:0] alarm_event_i, alarm_sw_clear_i, alarm_latched_o;
  logic [31:0] s;
  logic [4:0] a;
  dsacr_sample_t sample_i, sample_o;
  dsacr_sync_t fifo_sync_o;
  dsacr_scale_t current_scale_o;
  int num_errors = 0;
  int comparisons = 0;
  int seed = 32'hd8a9268f;
  int loads = 0;
  // Bank drives the data wire only while its enable is low
  assign sdio_i = sdio_oe_n_o ? sdio_host : sdio_o;
  dsacr_config_regs dsacr_config_regs_inst (.clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i), .sif_clk_i(sif_clk_i), .sdio_i(sdio_i),
    .sif_enable_n_i(sif_enable_n_i), .sdio_o(sdio_o),
    .sdio_oe_n_o(sdio_oe_n_o), .frame_sync_i(frame_sync_i),
    .multi_sync_en_i(multi_sync_en_i), .temp_sensor_i(temp_sensor_i),
    .sample_i(sample_i), .sample_o(sample_o), .alarm_event_i(alarm_event_i),
    .alarm_sw_clear_i(alarm_sw_clear_i), .good_sample_i(good_sample_i),
    .alarm_latched_o(alarm_latched_o), .fifo_sync_o(fifo_sync_o),
    .alarm_output_pin_o(alarm_output_pin_o),
    .current_scale_o(current_scale_o));
  dsacr_host_model dsacr_host_model_inst (.clk_sys_i(clk_sys_i),
    .sdio_wire_i(sdio_i), .sif_clk_o(sif_clk_i),
    .sif_enable_n_o(sif_enable_n_i), .sdio_host_o(sdio_host));
  // ****
  // Helpers
  // ****
  function automatic logic pin_exp(logic [6:0] lat, logic [6:0] m);
    return |(lat & ~m); // Masked: latched but off the pin
  endfunction
  task automatic check(input string what, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic clks(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wr(input logic [4:0] ad, input logic [7:0] d);
    dsacr_host_model_inst.xfer(1'b0, ad, d, rd);
  endtask
  task automatic rdchk(input logic [4:0] ad, input logic [7:0] e);
    dsacr_host_model_inst.xfer(1'b1, ad, 8'h00, rd);
    check("readback", e, rd);
  endtask
  task automatic pulse(input logic [6:0] e);
    @(posedge clk_sys_i);
    alarm_event_i <= e;
    @(posedge clk_sys_i);
    alarm_event_i <= 7'h00;
    clks(2);
  endtask
  task automatic goods(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      good_sample_i <= 1'b1;
      @(posedge clk_sys_i);
      good_sample_i <= 1'b0;
    end
    #1;
  endtask
  task automatic summarize;
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ****
  // Clock, watchdog and tests
  // ****
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
    if (fifo_sync_o.load === 1'b1) loads++;
  initial begin
    #3_000_000; // Nearly four times the expected run
    num_errors++;
    summarize();
  end
  initial begin
    reset_n_i = 1'b0;
    frame_sync_i = 1'b0;
    multi_sync_en_i = 1'b1;
    temp_sensor_i = 8'h00;
    sample_i = 32'h0;
    alarm_event_i = 7'h00;
    alarm_sw_clear_i = 7'h00;
    good_sample_i = 1'b0;
    repeat (8) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    clks(3);
    check("scale", 8'hFF, current_scale_o);
    check("offset", 3'h4, fifo_sync_o.offset);
    rdchk(5'h02, 8'h00);
    rdchk(5'h03, 8'h10);
    rdchk(5'h04, 8'hFF);
    rdchk(5'h06, 8'h00);
    // All-ones first proves reserved bits are storage
    for (int i = 0; i < 8; i++) begin
      a = (i % 4 == 3) ? 5'h06 : 5'(2 + i % 4);
      v = (i < 4) ? 8'hFF : 8'($random(seed));
      wr(a, v);
      rdchk(a, v);
      if (a == 5'h04) check("scale", v, current_scale_o);
      if (a == 5'h03) check("offset", v[4:2], fifo_sync_o.offset);
    end
    t = 8'($random(seed));
    @(posedge clk_sys_i);
    temp_sensor_i <= t;
    clks(6);
    rdchk(5'h05, t);
    wr(5'h05, ~t);
    rdchk(5'h05, t);
    rdchk(5'h10, 8'h00);
    for (int d = 0; d < 4; d++) begin
      wr(5'h02, 8'(d));
      @(posedge clk_sys_i);
      sample_i <= 32'h0;
      clks(6);
      s = $random(seed);
      @(posedge clk_sys_i);
      sample_i <= s;
      repeat (d) @(posedge clk_sys_i);
      #1 check("early", 32'h0, sample_o);
      clks(1);
      check("delayed", s, sample_o);
    end
    wr(5'h02, 8'h10);
    @(posedge clk_sys_i);
    frame_sync_i <= 1'b1;
    clks(6);
    loads = 0;
    check("level", 1'b0, fifo_sync_o.level);
    wr(5'h02, 8'h30);
    check("level", 1'b1, fifo_sync_o.level);
    wr(5'h02, 8'h30);
    check("loads", 1, loads);
    wr(5'h02, 8'h10);
    check("level", 1'b0, fifo_sync_o.level);
    wr(5'h02, 8'h00);
    check("loads", 2, loads);
    multi_sync_en_i <= 1'b0;
    wr(5'h02, 8'h10);
    wr(5'h02, 8'h30);
    check("loads", 2, loads);
    wr(5'h06, 8'h00);
    wr(5'h03, 8'h10);
    pulse(7'h03);
    check("latched", 7'h00, alarm_latched_o);
    wr(5'h03, 8'h13);
    pulse(7'h03);
    check("latched", 7'h03, alarm_latched_o);
    for (int m = 0; m < 4; m++) begin
      wr(5'h06, 8'(m));
      check("pin", pin_exp(7'h03, 7'(m)), alarm_output_pin_o);
    end
    check("latched", 7'h03, alarm_latched_o);
    @(posedge clk_sys_i);
    alarm_sw_clear_i <= 7'h7F;
    @(posedge clk_sys_i);
    alarm_sw_clear_i <= 7'h00;
    clks(1);
    check("swclear", 7'h00, alarm_latched_o);
    wr(5'h03, 8'h90);
    pulse(7'h08);
    goods(40);
    pulse(7'h08);
    goods(63);
    check("kept", 7'h08, alarm_latched_o);
    goods(1);
    check("autoclear", 7'h00, alarm_latched_o);
    summarize();
  end
endmodule
